// *** logic/gtpc_pkg.sv ***
// Purpose: constants for the timer pair with event capture
// Assumes: APB byte addresses, 32-bit data, one word per register
// Notes: all offsets, field positions and reset values live here
//
// Summary of operation
// - first timer capture register is read-only and holds the latched 32-bit count
// - control 31:24 takes the postscale target; a written zero counts as one
// - reading control 31:24 returns the live postscale counter
// - control bit 23 turns the postscaler on, clearing it turns it off
// - control bit 19 is a read-only flag set when timeouts reach target
// - control bit 18 picks postscaler or every timeout as interrupt source
// - control bit 17 enables event time capture
// - control bits 16:12 pick which interrupt event triggers the capture
// - control bits 10:9 pick slow, divided fast, fast or pin clock
// - control bit 8 set counts up, clear counts down
// - control bit 7 enables the first timer, default disabled
// - control bit 6 set is periodic, clear is free running
// - control bits 5:4 pick binary, 23-hour or 255-hour time format
// - control bits 3:0 pick prescale 1, 16, 256 or 32768
// - wake-up timer is 32-bit up/down with four prescaler sources
// - wake-up timer keeps counting while the core clock is stopped
// - wake-up timer reloads on overflow in periodic mode and at once on load write
// - any write to wake-up clear register clears its interrupt
// - wake-up value is read-only, live, and resets to all ones
// - periodic restarts from load, free running restarts from extreme
// - a timeout interrupt comes at zero counting down, full scale up
// - capture copies the count while the timer keeps counting
// - first timer reloads from its load register on overflow in periodic mode
package gtpc_pkg;
    localparam logic [31:0] ADDR_T0_LOAD = 32'hffff0320;
    localparam logic [31:0] ADDR_T0_VALUE = 32'hffff0324;
    localparam logic [31:0] ADDR_T0_CTRL = 32'hffff0328;
    localparam logic [31:0] ADDR_T0_CLEAR = 32'hffff032c;
    localparam logic [31:0] ADDR_T0_CAP = 32'hffff0330;
    localparam logic [31:0] ADDR_WK_LOAD = 32'hffff0340;
    localparam logic [31:0] ADDR_WK_VALUE = 32'hffff0344;
    localparam logic [31:0] ADDR_WK_CTRL = 32'hffff0348;
    localparam logic [31:0] ADDR_WK_CLEAR = 32'hffff034c;

    localparam logic [31:0] T0_CTRL_RST = 32'h01000000;
    localparam logic [31:0] VALUE_RST = 32'hffffffff;
    localparam logic [31:0] LOAD_RST = 32'h00000000;
    localparam logic [31:0] CAP_RST = 32'h00000000;
    localparam logic [15:0] WK_CTRL_RST = 16'h0200;

    localparam logic [31:0] T0_CTRL_WMASK = 32'h0087f7ff;
    localparam logic [15:0] WK_CTRL_WMASK = 16'h07ff;

    localparam int PS_HI = 31;
    localparam int PS_LO = 24;
    localparam int PS_EN_BIT = 23;
    localparam int PS_FLAG_BIT = 19;
    localparam int SRC_BIT = 18;
    localparam int CAP_EN_BIT = 17;
    localparam int CAPSEL_HI = 16;
    localparam int CAPSEL_LO = 12;
    localparam int CLK_HI = 10;
    localparam int CLK_LO = 9;
    localparam int DIR_BIT = 8;
    localparam int EN_BIT = 7;
    localparam int MOD_BIT = 6;
    localparam int FMT_HI = 5;
    localparam int FMT_LO = 4;
    localparam int SCALE_HI = 3;
    localparam int SCALE_LO = 0;

    localparam logic [1:0] FMT_BIN = 2'h0;
    localparam logic [1:0] FMT_H23 = 2'h2;
    localparam logic [1:0] FMT_H255 = 2'h3;
    localparam logic [1:0] CLK_SLOW = 2'h0;
    localparam logic [1:0] CLK_DIV = 2'h1;
    localparam logic [1:0] CLK_FAST = 2'h2;
    localparam logic [1:0] CLK_PIN = 2'h3;
    localparam logic [1:0] WCLK_SLOW = 2'h0;
    localparam logic [1:0] WCLK_DIV = 2'h1;
    localparam logic [1:0] WCLK_XTAL = 2'h2;
    localparam logic [1:0] WCLK_FAST = 2'h3;

    localparam logic [3:0] SCALE_1 = 4'h0;
    localparam logic [3:0] SCALE_16 = 4'h4;
    localparam logic [3:0] SCALE_256 = 4'h8;
    localparam logic [3:0] SCALE_32K = 4'hf;

    localparam logic [7:0] HUND_MAX = 8'h63;
    localparam logic [7:0] MINSEC_MAX = 8'h3b;
    localparam logic [7:0] HOUR_LIM23 = 8'h17;
    localparam logic [7:0] HOUR_LIM255 = 8'hff;
    localparam logic [7:0] PS_TARGET_RST = 8'h01;
    localparam int NUM_EVENTS = 18;
    localparam int EVT_T0 = 1;
    localparam int EVT_WK = 2;
endpackage

// *** logic/gtpc_prescale.sv ***
// Purpose: divides a tick stream by 1, 16, 256 or 32768
// Assumes: tick_in is a one-cycle pulse on core_clk
// Notes: undefined scale codes divide by one
`timescale 1ns/10ps
module gtpc_prescale
    import gtpc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // control
    input wire logic run,
    input wire logic [3:0] scale,
    // ticks
    input wire logic tick_in,
    output logic tick_out
);
    logic [14:0] div_ff;
    logic [14:0] mask;

    always_comb
    begin
        case (scale)
            SCALE_16: mask = 15'h000f;
            SCALE_256: mask = 15'h00ff;
            SCALE_32K: mask = 15'h7fff;
            default: mask = 15'h0000;
        endcase
    end

    // held at zero while stopped so a restart gives a full first period
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            div_ff <= 15'h0000;
        else if (clk_en)
        begin
            if (!run)
                div_ff <= 15'h0000;
            else if (tick_in)
                div_ff <= (div_ff & mask) == mask ? 15'h0000 : div_ff + 15'h0001;
        end
    end

    assign tick_out = run && tick_in && ((div_ff & mask) == mask);
endmodule

// *** logic/gtpc_timers.sv ***
// Purpose: first timer with postscaler and capture, plus wake-up timer
// Assumes: clock sources arrive as pins and are sampled on core_clk
// Notes: pready follows clk_en; read data is sampled in the setup cycle
`timescale 1ns/10ps
module gtpc_timers
    import gtpc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // clock source pins
    input wire logic slow_osc_pin,
    input wire logic fast_osc_pin,
    input wire logic xtal_pin,
    input wire logic external_count_pin,
    input wire logic [2:0] core_clock_divider,
    input wire logic cpu_sleep,
    // enabled interrupt events
    input wire logic [17:0] irq_events,
    // timer interrupts
    output logic first_timer_irq,
    output logic wakeup_irq
);
    logic [3:0] sync1_ff, sync2_ff, sync3_ff;
    logic [3:0] pin_tick;
    logic [6:0] cd_cnt_ff;
    logic [6:0] cd_mask;
    logic div_tick;
    logic [31:0] t0_load_ff, t0_cnt_ff, t0_ctrl_ff, t0_cap_ff;
    logic [31:0] wk_load_ff, wk_cnt_ff;
    logic [15:0] wk_ctrl_ff;
    logic [7:0] ps_target_ff, ps_cnt_ff;
    logic ps_flag_ff, t0_irq_ff, wk_irq_ff, evt_prev_ff;
    logic [31:0] prdata_ff;
    logic t0_src_tick, t0_tick, t0_term, t0_to, ps_hit;
    logic wk_src_tick, wk_tick, wk_term, wk_to;
    logic [31:0] t0_ctrl_rd;
    logic [31:0] evt_all;
    logic evt_sel, cap_trig;
    logic setup, wr, wr_t0_ctrl, wr_t0_load, wr_t0_clr, wr_wk_ctrl, wr_wk_load, wr_wk_clr;
    logic mapped;

    function automatic logic [31:0] full_of(input logic [1:0] fmt);
        if (fmt == FMT_H23)
            full_of = {HOUR_LIM23, MINSEC_MAX, MINSEC_MAX, HUND_MAX};
        else if (fmt == FMT_H255)
            full_of = {HOUR_LIM255, MINSEC_MAX, MINSEC_MAX, HUND_MAX};
        else
            full_of = VALUE_RST;
    endfunction

    // one step with hundredths/seconds/minutes/hours carries in time format
    function automatic logic [31:0] step(input logic [31:0] cur, input logic up,
                                         input logic [1:0] fmt);
        logic [31:0] r;
        r = cur;
        if (fmt != FMT_H23 && fmt != FMT_H255)
            r = up ? cur + 32'h1 : cur - 32'h1;
        else if (up)
        begin
            if (cur[7:0] != HUND_MAX)
                r[7:0] = cur[7:0] + 8'h01;
            else
            begin
                r[7:0] = 8'h00;
                if (cur[15:8] != MINSEC_MAX)
                    r[15:8] = cur[15:8] + 8'h01;
                else
                begin
                    r[15:8] = 8'h00;
                    if (cur[23:16] != MINSEC_MAX)
                        r[23:16] = cur[23:16] + 8'h01;
                    else
                    begin
                        r[23:16] = 8'h00;
                        r[31:24] = cur[31:24] + 8'h01;
                    end
                end
            end
        end
        else
        begin
            if (cur[7:0] != 8'h00)
                r[7:0] = cur[7:0] - 8'h01;
            else
            begin
                r[7:0] = HUND_MAX;
                if (cur[15:8] != 8'h00)
                    r[15:8] = cur[15:8] - 8'h01;
                else
                begin
                    r[15:8] = MINSEC_MAX;
                    if (cur[23:16] != 8'h00)
                        r[23:16] = cur[23:16] - 8'h01;
                    else
                    begin
                        r[23:16] = MINSEC_MAX;
                        r[31:24] = cur[31:24] - 8'h01;
                    end
                end
            end
        end
        step = r;
    endfunction

    // apb decode
    assign setup = psel && !penable && clk_en;
    assign wr = psel && penable && pwrite && clk_en;
    assign wr_t0_ctrl = wr && paddr == ADDR_T0_CTRL;
    assign wr_t0_load = wr && paddr == ADDR_T0_LOAD;
    assign wr_t0_clr = wr && paddr == ADDR_T0_CLEAR;
    assign wr_wk_ctrl = wr && paddr == ADDR_WK_CTRL;
    assign wr_wk_load = wr && paddr == ADDR_WK_LOAD;
    assign wr_wk_clr = wr && paddr == ADDR_WK_CLEAR;

    always_comb
    begin
        if (paddr == ADDR_T0_LOAD || paddr == ADDR_T0_VALUE || paddr == ADDR_T0_CTRL)
            mapped = 1'b1;
        else if (paddr == ADDR_T0_CLEAR || paddr == ADDR_T0_CAP)
            mapped = 1'b1;
        else if (paddr == ADDR_WK_LOAD || paddr == ADDR_WK_VALUE)
            mapped = 1'b1;
        else if (paddr == ADDR_WK_CTRL || paddr == ADDR_WK_CLEAR)
            mapped = 1'b1;
        else
            mapped = 1'b0;
    end

    assign pready = clk_en;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_ff;

    // the reserved bits and the flag never hold state; bits 31:24 show the counter
    assign t0_ctrl_rd = {ps_cnt_ff, 24'h000000} | (t0_ctrl_ff & T0_CTRL_WMASK)
        | (32'(ps_flag_ff) << PS_FLAG_BIT);

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            prdata_ff <= 32'h00000000;
        else if (setup && !pwrite)
        begin
            if (paddr == ADDR_T0_LOAD)
                prdata_ff <= t0_load_ff;
            else if (paddr == ADDR_T0_VALUE)
                prdata_ff <= t0_cnt_ff;
            else if (paddr == ADDR_T0_CTRL)
                prdata_ff <= t0_ctrl_rd;
            else if (paddr == ADDR_T0_CAP)
                prdata_ff <= t0_cap_ff;
            else if (paddr == ADDR_WK_LOAD)
                prdata_ff <= wk_load_ff;
            else if (paddr == ADDR_WK_VALUE)
                prdata_ff <= wk_cnt_ff;
            else if (paddr == ADDR_WK_CTRL)
                prdata_ff <= {16'h0000, wk_ctrl_ff};
            else
                prdata_ff <= 32'h00000000;
        end
    end

    // pin synchronisers: slow, fast, crystal, external
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            sync3_ff <= 4'h0;
        end
        else if (clk_en)
        begin
            sync1_ff <= {external_count_pin, xtal_pin, fast_osc_pin, slow_osc_pin};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    assign pin_tick = sync2_ff & ~sync3_ff;

    // fast clock over the core divider, a power of two
    assign cd_mask = 7'((8'h01 << core_clock_divider) - 8'h01);
    assign div_tick = pin_tick[1] && ((cd_cnt_ff & cd_mask) == cd_mask);

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            cd_cnt_ff <= 7'h00;
        else if (clk_en && pin_tick[1])
            cd_cnt_ff <= (cd_cnt_ff & cd_mask) == cd_mask ? 7'h00 : cd_cnt_ff + 7'h01;
    end

    // fast-derived sources stop with the core; slow and pin keep going
    always_comb
    begin
        case (t0_ctrl_ff[CLK_HI:CLK_LO])
            CLK_SLOW: t0_src_tick = pin_tick[0];
            CLK_DIV: t0_src_tick = div_tick && !cpu_sleep;
            CLK_FAST: t0_src_tick = pin_tick[1] && !cpu_sleep;
            default: t0_src_tick = pin_tick[3];
        endcase
    end

    // wake-up sources ignore cpu_sleep so it runs with the core stopped
    always_comb
    begin
        case (wk_ctrl_ff[CLK_HI:CLK_LO])
            WCLK_SLOW: wk_src_tick = pin_tick[0];
            WCLK_DIV: wk_src_tick = div_tick;
            WCLK_XTAL: wk_src_tick = pin_tick[2];
            default: wk_src_tick = pin_tick[1];
        endcase
    end

    gtpc_prescale u_t0_scale (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .run(t0_ctrl_ff[EN_BIT]),
        .scale(t0_ctrl_ff[SCALE_HI:SCALE_LO]),
        .tick_in(t0_src_tick),
        .tick_out(t0_tick)
    );

    gtpc_prescale u_wk_scale (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .run(wk_ctrl_ff[EN_BIT]),
        .scale(wk_ctrl_ff[SCALE_HI:SCALE_LO]),
        .tick_in(wk_src_tick),
        .tick_out(wk_tick)
    );

    assign t0_term = t0_ctrl_ff[DIR_BIT] ? t0_cnt_ff == full_of(t0_ctrl_ff[FMT_HI:FMT_LO])
        : t0_cnt_ff == 32'h0;
    assign t0_to = t0_tick && t0_term;
    assign wk_term = wk_ctrl_ff[DIR_BIT] ? wk_cnt_ff == full_of(wk_ctrl_ff[FMT_HI:FMT_LO])
        : wk_cnt_ff == 32'h0;
    assign wk_to = wk_tick && wk_term;

    // first timer registers
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            t0_ctrl_ff <= T0_CTRL_RST & T0_CTRL_WMASK;
            t0_load_ff <= LOAD_RST;
        end
        else if (clk_en)
        begin
            if (wr_t0_ctrl)
                t0_ctrl_ff <= pwdata & T0_CTRL_WMASK;
            if (wr_t0_load)
                t0_load_ff <= pwdata;
        end
    end

    // writing control in periodic mode starts the count from the load value
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            t0_cnt_ff <= VALUE_RST;
        else if (clk_en)
        begin
            if (wr_t0_ctrl && pwdata[MOD_BIT])
                t0_cnt_ff <= t0_load_ff;
            else if (t0_to)
            begin
                if (t0_ctrl_ff[MOD_BIT])
                    t0_cnt_ff <= t0_load_ff;
                else
                    t0_cnt_ff <= t0_ctrl_ff[DIR_BIT] ? 32'h0
                        : full_of(t0_ctrl_ff[FMT_HI:FMT_LO]);
            end
            else if (t0_tick)
                t0_cnt_ff <= step(t0_cnt_ff, t0_ctrl_ff[DIR_BIT],
                                  t0_ctrl_ff[FMT_HI:FMT_LO]);
        end
    end

    // postscaler counts timeouts up to the target
    assign ps_hit = t0_to && t0_ctrl_ff[PS_EN_BIT] && (ps_cnt_ff + 8'h01 == ps_target_ff);

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ps_target_ff <= PS_TARGET_RST;
            ps_cnt_ff <= 8'h00;
        end
        else if (clk_en)
        begin
            if (wr_t0_ctrl)
            begin
                ps_target_ff <= pwdata[PS_HI:PS_LO] == 8'h00 ? PS_TARGET_RST
                    : pwdata[PS_HI:PS_LO];
                ps_cnt_ff <= 8'h00;
            end
            else if (ps_hit)
                ps_cnt_ff <= 8'h00;
            else if (t0_to && t0_ctrl_ff[PS_EN_BIT])
                ps_cnt_ff <= ps_cnt_ff + 8'h01;
        end
    end

    // flags: a set in the same cycle as a clear wins
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ps_flag_ff <= 1'b0;
            t0_irq_ff <= 1'b0;
            wk_irq_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (ps_hit)
                ps_flag_ff <= 1'b1;
            else if (wr_t0_clr)
                ps_flag_ff <= 1'b0;
            if (t0_ctrl_ff[SRC_BIT] ? ps_hit : t0_to)
                t0_irq_ff <= 1'b1;
            else if (wr_t0_clr)
                t0_irq_ff <= 1'b0;
            if (wk_to)
                wk_irq_ff <= 1'b1;
            else if (wr_wk_clr)
                wk_irq_ff <= 1'b0;
        end
    end

    assign first_timer_irq = t0_irq_ff;
    assign wakeup_irq = wk_irq_ff;

    // capture on the first cycle of each assertion of the chosen event
    assign evt_all = {14'h0000, irq_events}
        | (32'(t0_irq_ff) << EVT_T0) | (32'(wk_irq_ff) << EVT_WK);
    assign evt_sel = evt_all[t0_ctrl_ff[CAPSEL_HI:CAPSEL_LO]];
    assign cap_trig = t0_ctrl_ff[CAP_EN_BIT] && evt_sel && !evt_prev_ff;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            evt_prev_ff <= 1'b0;
            t0_cap_ff <= CAP_RST;
        end
        else if (clk_en)
        begin
            evt_prev_ff <= evt_sel;
            if (cap_trig)
                t0_cap_ff <= t0_cnt_ff;
        end
    end

    // wake-up timer
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wk_ctrl_ff <= WK_CTRL_RST;
            wk_load_ff <= LOAD_RST;
        end
        else if (clk_en)
        begin
            if (wr_wk_ctrl)
                wk_ctrl_ff <= pwdata[15:0] & WK_CTRL_WMASK;
            if (wr_wk_load)
                wk_load_ff <= pwdata;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            wk_cnt_ff <= VALUE_RST;
        else if (clk_en)
        begin
            if (wr_wk_load)
                wk_cnt_ff <= pwdata;
            else if (wr_wk_ctrl && pwdata[MOD_BIT])
                wk_cnt_ff <= wk_load_ff;
            else if (wk_to)
                wk_cnt_ff <= wk_ctrl_ff[MOD_BIT] ? wk_load_ff
                    : (wk_ctrl_ff[DIR_BIT] ? 32'h0 : full_of(wk_ctrl_ff[FMT_HI:FMT_LO]));
            else if (wk_tick)
                wk_cnt_ff <= step(wk_cnt_ff, wk_ctrl_ff[DIR_BIT],
                                  wk_ctrl_ff[FMT_HI:FMT_LO]);
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    sequence ctrl_write_s;
        wr_t0_ctrl;
    endsequence

    sequence load_write_s;
        wr_wk_load;
    endsequence

    capture_copy_a: assert property (clk_en && cap_trig
        |=> t0_cap_ff == $past(t0_cnt_ff))
        else $error("capture did not copy the count");
    capture_off_a: assert property (clk_en && !t0_ctrl_ff[CAP_EN_BIT] |=> $stable(t0_cap_ff))
        else $error("capture changed while disabled");
    ps_zero_a: assert property (ctrl_write_s ##0 pwdata[PS_HI:PS_LO] == 8'h00
        |=> ps_target_ff == PS_TARGET_RST)
        else $error("zero target not taken as one");
    ps_read_a: assert property (setup && !pwrite && paddr == ADDR_T0_CTRL
        |=> prdata[PS_HI:PS_LO] == $past(ps_cnt_ff))
        else $error("control read does not show postscale counter");
    ps_flag_a: assert property (clk_en && ps_hit |=> ps_flag_ff && t0_ctrl_rd[PS_FLAG_BIT])
        else $error("match flag not set");
    irq_direct_a: assert property (clk_en && t0_to && !t0_ctrl_ff[SRC_BIT]
        |=> first_timer_irq)
        else $error("direct timeout gave no interrupt");
    irq_ps_a: assert property (t0_to && t0_ctrl_ff[SRC_BIT] && !ps_hit && !first_timer_irq
        && clk_en |=> !first_timer_irq)
        else $error("postscaled interrupt before target");
    count_up_a: assert property (clk_en && t0_tick && !t0_term && !wr_t0_ctrl
        && t0_ctrl_ff[DIR_BIT] && t0_ctrl_ff[FMT_HI:FMT_LO] == FMT_BIN
        |=> t0_cnt_ff == $past(t0_cnt_ff) + 32'h1)
        else $error("up count did not increment");
    disabled_hold_a: assert property (clk_en && !t0_ctrl_ff[EN_BIT] && !wr_t0_ctrl
        |=> $stable(t0_cnt_ff))
        else $error("disabled timer moved");
    wk_load_a: assert property (load_write_s |=> wk_cnt_ff == $past(pwdata))
        else $error("load write did not reload at once");
    wk_clear_a: assert property (wr_wk_clr && !wk_to |=> !wakeup_irq)
        else $error("clear write left interrupt pending");
endmodule

// *** tb/gtpc_testbench.sv ***
// Purpose: self-checking bench for the timer pair
// Assumes: clk_en held high, so apb completes in one access cycle
// Notes: one stimulus line feeds all four clock pins
`timescale 1ns/10ps
module testbench;
    import gtpc_pkg::*;
    logic core_clk, sys_rst, clk_en, psel, penable, pwrite, src, cpu_sleep, err_bit;
    logic pready, pslverr, first_timer_irq, wakeup_irq;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [2:0] core_clock_divider;
    logic [17:0] irq_events;
    int err_count, samples_checked;

    gtpc_timers dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .slow_osc_pin(src),
        .fast_osc_pin(src), .xtal_pin(src), .external_count_pin(src),
        .core_clock_divider(core_clock_divider), .cpu_sleep(cpu_sleep),
        .irq_events(irq_events), .first_timer_irq(first_timer_irq), .wakeup_irq(wakeup_irq));

    initial
    begin
        core_clk = 1'h0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request held until pready is sampled high, then released
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        do
        begin
            @(posedge core_clk);
        end
        while (pready !== 1'h1);
        rd = prdata;
        err_bit = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // pins are synchronised, so each level is held three cycles
    task automatic tick(input int n);
        repeat (n)
        begin
            src <= 1'h1;
            repeat (3) @(posedge core_clk);
            src <= 1'h0;
            repeat (3) @(posedge core_clk);
        end
        repeat (6) @(posedge core_clk);
    endtask

    task automatic test_reset;
        apb(1'h0, ADDR_T0_CTRL, 32'h0);
        check("first_ctrl", 32'h00000000, rd);
        apb(1'h0, ADDR_T0_CAP, 32'h0);
        check("capture", CAP_RST, rd);
        apb(1'h0, ADDR_WK_VALUE, 32'h0);
        check("wake_value", VALUE_RST, rd);
        $display("test_reset done");
    endtask

    task automatic test_wake;
        apb(1'h1, ADDR_WK_LOAD, 32'h12345678);
        apb(1'h0, ADDR_WK_VALUE, 32'h0);
        check("wake_reload", 32'h12345678, rd);
        apb(1'h1, ADDR_WK_VALUE, 32'h0);
        apb(1'h0, ADDR_WK_VALUE, 32'h0);
        check("wake_ro", 32'h12345678, rd);
        apb(1'h1, ADDR_WK_LOAD, 32'h2);
        apb(1'h1, ADDR_WK_CTRL, 32'h000006c0);
        cpu_sleep <= 1'h1;
        tick(3);
        check("wake_sleep_irq", 32'h1, {31'h0, wakeup_irq});
        cpu_sleep <= 1'h0;
        apb(1'h1, ADDR_WK_CLEAR, 32'h5a);
        @(posedge core_clk);
        check("wake_irq", 32'h0, {31'h0, wakeup_irq});
        apb(1'h0, 32'hffff0350, 32'h0);
        check("unmapped", 32'h1, {31'h0, err_bit});
        $display("test_wake done");
    endtask

    // load 5, fast clock, periodic, down, prescale 1: timeout on sixth tick
    task automatic test_period;
        apb(1'h1, ADDR_T0_LOAD, 32'h5);
        apb(1'h1, ADDR_T0_CTRL, 32'h000004c0);
        tick(5);
        check("irq_early", 32'h0, {31'h0, first_timer_irq});
        tick(1);
        check("irq_zero", 32'h1, {31'h0, first_timer_irq});
        apb(1'h0, ADDR_T0_VALUE, 32'h0);
        check("reload", 32'h5, rd);
        apb(1'h1, ADDR_T0_CLEAR, 32'h0);
        repeat (2) @(posedge core_clk);
        check("irq_clear", 32'h0, {31'h0, first_timer_irq});
        $display("test_period done");
    endtask

    task automatic test_capture;
        apb(1'h1, ADDR_T0_CTRL, 32'h000234c0);
        tick(2);
        irq_events <= 18'h8;
        repeat (3) @(posedge core_clk);
        apb(1'h0, ADDR_T0_CAP, 32'h0);
        check("capture", 32'h3, rd);
        tick(1);
        apb(1'h0, ADDR_T0_VALUE, 32'h0);
        check("count_on", 32'h2, rd);
        apb(1'h0, ADDR_T0_CAP, 32'h0);
        check("capture_held", 32'h3, rd);
        irq_events <= 18'h0;
        $display("test_capture done");
    endtask

    // target 2: interrupt only after the second timeout
    task automatic test_post;
        apb(1'h1, ADDR_T0_CTRL, 32'h028404c0);
        tick(6);
        check("post_irq1", 32'h0, {31'h0, first_timer_irq});
        apb(1'h0, ADDR_T0_CTRL, 32'h0);
        check("post_count", 32'h018404c0, rd);
        tick(6);
        check("post_irq2", 32'h1, {31'h0, first_timer_irq});
        apb(1'h0, ADDR_T0_CTRL, 32'h0);
        check("post_flag", 32'h008c04c0, rd);
        apb(1'h1, ADDR_T0_CLEAR, 32'h0);
        apb(1'h1, ADDR_T0_CTRL, 32'h008404c0);
        tick(6);
        check("post_zero", 32'h1, {31'h0, first_timer_irq});
        $display("test_post done");
    endtask

    // binary up one step, then time format carries 0:00:59:99 into the minutes
    task automatic test_format;
        apb(1'h1, ADDR_T0_LOAD, 32'h00003b62);
        apb(1'h1, ADDR_T0_CTRL, 32'h000005c0);
        tick(1);
        apb(1'h0, ADDR_T0_VALUE, 32'h0);
        check("count_up", 32'h00003b63, rd);
        apb(1'h1, ADDR_T0_CTRL, 32'h000005e0);
        tick(2);
        apb(1'h0, ADDR_T0_VALUE, 32'h0);
        check("time_carry", 32'h00010000, rd);
        $display("test_format done");
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        end_of_test;
    end

    initial
    begin
        {sys_rst, clk_en} = 2'h3;
        {psel, penable, pwrite, src, cpu_sleep} = 5'h0;
        {paddr, pwdata} = 64'h0;
        core_clock_divider = 3'h0;
        irq_events = 18'h0;
        err_count = 0;
        samples_checked = 0;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'h0;
        test_reset;
        test_wake;
        test_period;
        test_capture;
        test_post;
        test_format;
        end_of_test;
    end
endmodule
